/* design/lbn_pkg.sv */
package lbn_pkg;
    localparam int CS_COUNT     = 8;
    localparam int CS_SEL_W     = 3;
    localparam int ADDR_W       = 26;
    localparam int DATA_W       = 32;
    localparam int WAIT_FIELD_W = 8;
    localparam int WAIT_W       = 16;
    localparam int TURN_W       = 2;
    localparam int SIZE_W       = 2;
    localparam int CNT_W        = 17;
    localparam int BUS_MAX_MHZ  = 66;
    localparam int PCI_MIN_66_NS = 15;
    localparam int PCI_MIN_33_NS = 30;
    localparam int CORE_PERIOD_NS = 4;
    localparam int NS_PER_US    = 1000;
    localparam logic [CS_COUNT-1:0] CS_IDLE = 8'hff;

    typedef enum logic [1:0] {
        LBN_LEGACY     = 2'h0,
        LBN_WIDE_FLASH = 2'h1,
        LBN_MEDIA      = 2'h2
    } lbn_mode_e;

    typedef enum logic [4:0] {
        LBN_IDLE   = 5'h01,
        LBN_SETUP  = 5'h02,
        LBN_ACTIVE = 5'h04,
        LBN_HOLD   = 5'h08,
        LBN_TURN   = 5'h10
    } lbn_state_e;
endpackage

/* design/lbn_cnt_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface lbn_cnt_if;
    logic                      load;
    logic [lbn_pkg::CNT_W-1:0] limit;
    logic                      expired;
    modport owner   (output load, output limit, input expired);
    modport counter (input load, input limit, output expired);
endinterface
`default_nettype wire

/* design/lbn_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module lbn_sync (
    input  wire logic clk,   // destination clock
    input  wire logic rst,   // async reset, active high
    input  wire logic d,     // level from the other domain
    output logic      q      // synchronised level
);
    logic meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* design/lbn_wait_cnt.sv */
`timescale 1ns/100ps
`default_nettype none
module lbn_wait_cnt (
    input  wire logic  clk,  // bus clock
    input  wire logic  rst,  // async reset, active high
    lbn_cnt_if.counter cnt   // load, limit and expiry
);
    logic [lbn_pkg::CNT_W-1:0] count_reg;

    assign cnt.expired = (count_reg == cnt.limit);

    // stops at the limit so a stalled owner never sees a wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (cnt.load) begin
            count_reg <= '0;
        end else if (!cnt.expired) begin
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* design/lbn_access.sv */
`timescale 1ns/100ps
`default_nettype none
module lbn_access #(
    parameter int PCI_PERIOD_NS = 30,
    parameter bit PCI_66        = 1'b0
) (
    input  wire logic                              CORE_CLK,         // core clock
    input  wire logic                              RST,              // async reset
    input  wire logic                              EB_CLK,           // bus clock
    input  wire logic                              CFG_WE,           // config write
    input  wire logic [lbn_pkg::CS_SEL_W-1:0]      CFG_SEL,          // config target
    input  wire logic                              CFG_ENABLE,       // select usable
    input  wire logic [lbn_pkg::WAIT_FIELD_W-1:0]  CFG_WAIT_PRIMARY, // wait low
    input  wire logic [lbn_pkg::WAIT_FIELD_W-1:0]  CFG_WAIT_EXTRA,   // wait high
    input  wire logic [lbn_pkg::TURN_W-1:0]        CFG_TURNAROUND,   // dead cycles
    input  wire logic [1:0]                        CFG_MODE,         // access mode
    input  wire logic                              REQ_VALID,        // start access
    input  wire logic [lbn_pkg::CS_SEL_W-1:0]      REQ_CS,           // target select
    input  wire logic [lbn_pkg::ADDR_W-1:0]        REQ_ADDR,         // address
    input  wire logic [lbn_pkg::DATA_W-1:0]        REQ_WDATA,        // write data
    input  wire logic                              REQ_RNW,          // 1 read
    input  wire logic [lbn_pkg::SIZE_W-1:0]        REQ_SIZE,         // size code
    output logic                                   BUSY,             // access open
    output logic                                   DONE,             // access ended
    output logic                                   REFUSED,          // select off
    output logic                                   ACKED,            // ended by ack
    output logic [lbn_pkg::DATA_W-1:0]             RDATA,            // read data
    output logic [lbn_pkg::WAIT_W-1:0]             STAT_WAIT,        // readback
    output logic [lbn_pkg::TURN_W-1:0]             STAT_TURN,        // readback
    output logic [1:0]                             STAT_MODE,        // readback
    output logic                                   STAT_ENABLE,      // readback
    output logic [lbn_pkg::CS_COUNT-1:0]           EB_CS_N,          // chip selects
    output logic                                   EB_OE_N,          // output enable
    output logic                                   EB_RNW,           // direction
    output logic [lbn_pkg::ADDR_W-1:0]             EB_ADDR,          // address
    output logic                                   EB_ADDR_OE,       // address drive
    output logic [lbn_pkg::DATA_W-1:0]             EB_DATA_O,        // data out
    output logic                                   EB_DATA_OE,       // data drive
    input  wire logic [lbn_pkg::DATA_W-1:0]        EB_DATA_I,        // data in
    input  wire logic                              EB_ACK_N,         // acknowledge
    output logic                                   EB_START_N,       // start pulse
    output logic [lbn_pkg::SIZE_W-1:0]             EB_SIZE,          // transfer size
    output logic                                   EB_SIZE_OE        // size drive
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the bus clock is made by this device's own generator and fed in
    // here; nothing on the pins is ever taken as the bus clock
    if (PCI_PERIOD_NS * lbn_pkg::BUS_MAX_MHZ < lbn_pkg::NS_PER_US) begin : g_fmax
        $error("bus clock above the permitted frequency");
    end
    if (PCI_PERIOD_NS < (PCI_66 ? lbn_pkg::PCI_MIN_66_NS
                                : lbn_pkg::PCI_MIN_33_NS)) begin : g_tmin
        $error("bus clock period below its minimum");
    end
    // setup and hold of one bus period must cover one core period
    if (PCI_PERIOD_NS < lbn_pkg::CORE_PERIOD_NS) begin : g_ipb
        $error("bus clock faster than the core clock");
    end

    // ------------------------------------------------------------
    // per select configuration, core domain
    // ------------------------------------------------------------
    logic [lbn_pkg::WAIT_W-1:0]  cfg_wait_reg [lbn_pkg::CS_COUNT];
    logic [lbn_pkg::TURN_W-1:0]  cfg_turn_reg [lbn_pkg::CS_COUNT];
    logic [1:0]                  cfg_mode_reg [lbn_pkg::CS_COUNT];
    logic [lbn_pkg::CS_COUNT-1:0] cfg_en_reg;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < lbn_pkg::CS_COUNT; i++) begin
                cfg_wait_reg[i] <= '0;
                cfg_turn_reg[i] <= '0;
                cfg_mode_reg[i] <= lbn_pkg::LBN_LEGACY;
            end
            cfg_en_reg <= '0;
        end else if (CFG_WE) begin
            cfg_wait_reg[CFG_SEL] <= {CFG_WAIT_EXTRA, CFG_WAIT_PRIMARY};
            cfg_turn_reg[CFG_SEL] <= CFG_TURNAROUND;
            cfg_mode_reg[CFG_SEL] <= CFG_MODE;
            cfg_en_reg[CFG_SEL]   <= CFG_ENABLE;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            STAT_WAIT   <= '0;
            STAT_TURN   <= '0;
            STAT_MODE   <= lbn_pkg::LBN_LEGACY;
            STAT_ENABLE <= 1'b0;
        end else begin
            STAT_WAIT   <= cfg_wait_reg[CFG_SEL];
            STAT_TURN   <= cfg_turn_reg[CFG_SEL];
            STAT_MODE   <= cfg_mode_reg[CFG_SEL];
            STAT_ENABLE <= cfg_en_reg[CFG_SEL];
        end
    end

    // ------------------------------------------------------------
    // request hand-off, core domain
    // ------------------------------------------------------------
    // the held fields stay still from the toggle until the link
    // reports back, so the link may read them after the sync
    logic [lbn_pkg::CS_SEL_W-1:0] h_cs_reg;
    logic [lbn_pkg::ADDR_W-1:0]   h_addr_reg;
    logic [lbn_pkg::DATA_W-1:0]   h_wdata_reg;
    logic                         h_rnw_reg;
    logic [lbn_pkg::SIZE_W-1:0]   h_size_reg;
    logic [lbn_pkg::WAIT_W-1:0]   h_wait_reg;
    logic [lbn_pkg::TURN_W-1:0]   h_turn_reg;
    logic [1:0]                   h_mode_reg;
    logic                         req_tgl_reg;
    logic                         done_seen_reg;
    logic                         done_sync;
    logic                         done_tgl_reg;
    logic [lbn_pkg::DATA_W-1:0]   l_rdata_reg;
    logic                         l_acked_reg;
    logic                         accept;
    logic                         finish;

    assign accept = REQ_VALID && !BUSY;
    assign finish = (done_sync != done_seen_reg);

    lbn_sync u_done_sync (
        .clk (CORE_CLK),
        .rst (RST),
        .d   (done_tgl_reg),
        .q   (done_sync)
    );

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            h_cs_reg    <= '0;
            h_addr_reg  <= '0;
            h_wdata_reg <= '0;
            h_rnw_reg   <= 1'b1;
            h_size_reg  <= '0;
            h_wait_reg  <= '0;
            h_turn_reg  <= '0;
            h_mode_reg  <= lbn_pkg::LBN_LEGACY;
        end else if (accept) begin
            h_cs_reg    <= REQ_CS;
            h_addr_reg  <= REQ_ADDR;
            h_wdata_reg <= REQ_WDATA;
            h_rnw_reg   <= REQ_RNW;
            h_size_reg  <= REQ_SIZE;
            h_wait_reg  <= cfg_wait_reg[REQ_CS];
            h_turn_reg  <= cfg_turn_reg[REQ_CS];
            h_mode_reg  <= cfg_mode_reg[REQ_CS];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            req_tgl_reg   <= 1'b0;
            done_seen_reg <= 1'b0;
            BUSY          <= 1'b0;
            DONE          <= 1'b0;
            REFUSED       <= 1'b0;
        end else begin
            DONE    <= 1'b0;
            REFUSED <= 1'b0;
            if (accept && !cfg_en_reg[REQ_CS]) begin
                REFUSED <= 1'b1;
            end else if (accept) begin
                req_tgl_reg <= !req_tgl_reg;
                BUSY        <= 1'b1;
            end
            if (finish) begin
                done_seen_reg <= done_sync;
                BUSY          <= 1'b0;
                DONE          <= 1'b1;
            end
        end
    end

    // link results are still until the next request is taken
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= '0;
            ACKED <= 1'b0;
        end else if (finish) begin
            RDATA <= l_rdata_reg;
            ACKED <= l_acked_reg;
        end
    end

    // ------------------------------------------------------------
    // bus side reset and request detection
    // ------------------------------------------------------------
    logic rst_l1_reg;
    logic rst_l2_reg;
    logic rst_link;
    logic req_sync;
    logic req_seen_reg;

    // asserts at once, releases on the bus clock
    always_ff @(posedge EB_CLK or posedge RST) begin
        if (RST) begin
            rst_l1_reg <= 1'b1;
            rst_l2_reg <= 1'b1;
        end else begin
            rst_l1_reg <= 1'b0;
            rst_l2_reg <= rst_l1_reg;
        end
    end
    assign rst_link = rst_l2_reg;

    lbn_sync u_req_sync (
        .clk (EB_CLK),
        .rst (rst_link),
        .d   (req_tgl_reg),
        .q   (req_sync)
    );

    // ------------------------------------------------------------
    // access sequencer, bus domain
    // ------------------------------------------------------------
    lbn_pkg::lbn_state_e state_reg;
    lbn_pkg::lbn_state_e state_next;
    lbn_cnt_if           cnt ();
    logic                ack_q_reg;
    logic                take;
    logic                wide;
    logic                media;
    logic                win_end;

    lbn_wait_cnt u_wait_cnt (
        .clk (EB_CLK),
        .rst (rst_link),
        .cnt (cnt)
    );

    assign take  = (state_reg == lbn_pkg::LBN_IDLE) && (req_sync != req_seen_reg);
    assign wide  = (h_mode_reg == lbn_pkg::LBN_WIDE_FLASH) || (h_mode_reg == lbn_pkg::LBN_MEDIA);
    assign media = (h_mode_reg == lbn_pkg::LBN_MEDIA);
    assign win_end = (state_reg == lbn_pkg::LBN_ACTIVE)
                     && (cnt.expired || ack_q_reg);

    // acknowledge and the window share this clock, so it is
    // registered once and acted on at the next edge
    always_ff @(posedge EB_CLK or posedge rst_link) begin
        if (rst_link) begin
            ack_q_reg <= 1'b0;
        end else begin
            ack_q_reg <= !EB_ACK_N && (state_reg == lbn_pkg::LBN_ACTIVE);
        end
    end

    always_comb begin
        cnt.load  = 1'b0;
        cnt.limit = {1'b0, h_wait_reg} + 1'b1;
        case (state_reg)
            lbn_pkg::LBN_SETUP: begin
                cnt.load = 1'b1;
            end
            lbn_pkg::LBN_ACTIVE: begin
                cnt.load = win_end;
            end
            lbn_pkg::LBN_HOLD,
            lbn_pkg::LBN_TURN: begin
                cnt.limit = lbn_pkg::CNT_W'(h_turn_reg);
            end
            default: begin
                cnt.load = 1'b0;
            end
        endcase
    end

    // one sequence for every mode: setup, window, hold, then turnaround only on reads with a nonzero turnaround
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            lbn_pkg::LBN_IDLE: begin
                if (take) begin
                    state_next = lbn_pkg::LBN_SETUP;
                end
            end
            lbn_pkg::LBN_SETUP: begin
                state_next = lbn_pkg::LBN_ACTIVE;
            end
            lbn_pkg::LBN_ACTIVE: begin
                if (win_end) begin
                    state_next = lbn_pkg::LBN_HOLD;
                end
            end
            lbn_pkg::LBN_HOLD: begin
                if (h_rnw_reg && !cnt.expired) begin
                    state_next = lbn_pkg::LBN_TURN;
                end else begin
                    state_next = lbn_pkg::LBN_IDLE;
                end
            end
            lbn_pkg::LBN_TURN: begin
                if (cnt.expired) begin
                    state_next = lbn_pkg::LBN_IDLE;
                end
            end
            default: begin
                state_next = lbn_pkg::LBN_IDLE;
            end
        endcase
    end

    always_ff @(posedge EB_CLK or posedge rst_link) begin
        if (rst_link) begin
            state_reg    <= lbn_pkg::LBN_IDLE;
            req_seen_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (take) begin
                req_seen_reg <= req_sync;
            end
            // report only once back in idle: the turnaround still reads
            // the held fields, which the next accepted request rewrites
            if (state_reg != lbn_pkg::LBN_IDLE && state_next == lbn_pkg::LBN_IDLE) begin
                done_tgl_reg <= !done_tgl_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // address, direction, data and size pins
    // ------------------------------------------------------------
    // all of these go out one bus period ahead of the select and, except
    // the address in the wide modes, stay one bus period past it,
    // which covers a core period
    always_ff @(posedge EB_CLK or posedge rst_link) begin
        if (rst_link) begin
            EB_ADDR    <= '0;
            EB_ADDR_OE <= 1'b0;
            EB_RNW     <= 1'b1;
            EB_DATA_O  <= '0;
            EB_DATA_OE <= 1'b0;
            EB_SIZE    <= '0;
            EB_SIZE_OE <= 1'b0;
        end else if (take) begin
            EB_ADDR    <= h_addr_reg;
            EB_ADDR_OE <= 1'b1;
            EB_RNW     <= h_rnw_reg;
            EB_DATA_O  <= h_wdata_reg;
            EB_DATA_OE <= !h_rnw_reg;
            EB_SIZE    <= h_size_reg;
            EB_SIZE_OE <= media;
        end else if (win_end && wide) begin
            // shared address pins let go with the select
            EB_ADDR_OE <= 1'b0;
        end else if (state_reg == lbn_pkg::LBN_HOLD) begin
            EB_ADDR_OE <= 1'b0;
            EB_RNW     <= 1'b1;
            EB_DATA_OE <= 1'b0;
            EB_SIZE_OE <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // select, output enable and start pins
    // ------------------------------------------------------------
    always_ff @(posedge EB_CLK or posedge rst_link) begin
        if (rst_link) begin
            EB_CS_N    <= lbn_pkg::CS_IDLE;
            EB_OE_N    <= 1'b1;
            EB_START_N <= 1'b1;
        end else begin
            EB_START_N <= 1'b1;
            if (state_reg == lbn_pkg::LBN_SETUP) begin
                EB_CS_N[h_cs_reg] <= 1'b0;
                EB_OE_N           <= !h_rnw_reg;
                EB_START_N        <= !wide;
            end else if (win_end) begin
                EB_CS_N <= lbn_pkg::CS_IDLE;
                EB_OE_N <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------
    always_ff @(posedge EB_CLK or posedge rst_link) begin
        if (rst_link) begin
            l_rdata_reg <= '0;
            l_acked_reg <= 1'b0;
        end else if (win_end) begin
            if (h_rnw_reg) begin
                l_rdata_reg <= EB_DATA_I;
            end
            l_acked_reg <= ack_q_reg;
        end
    end
endmodule
`default_nettype wire

/* sim/lbn_access_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module lbn_access_sva (
    input wire logic                            EB_CLK,     // bus clock
    input wire logic                            RST,        // async reset
    input wire logic [lbn_pkg::CS_COUNT-1:0]    EB_CS_N,    // selects
    input wire logic                            EB_OE_N,    // output enable
    input wire logic                            EB_RNW,     // direction
    input wire logic [lbn_pkg::ADDR_W-1:0]      EB_ADDR,    // address
    input wire logic                            EB_ADDR_OE, // address drive
    input wire logic [lbn_pkg::DATA_W-1:0]      EB_DATA_O,  // data out
    input wire logic                            EB_DATA_OE, // data drive
    input wire logic                            EB_ACK_N,   // acknowledge
    input wire logic                            EB_START_N, // start pulse
    input wire logic [lbn_pkg::SIZE_W-1:0]      EB_SIZE,    // size code
    input wire logic                            EB_SIZE_OE  // size drive
);
    logic cs_on;
    assign cs_on = ~&EB_CS_N;
    default clocking cb @(posedge EB_CLK); endclocking
    default disable iff (RST);
    sequence s_open;
        $rose(cs_on);
    endsequence
    // ----
    // window edges
    // ----
    a_one_select: assert property ($onehot0(~EB_CS_N))
        else $error("two selects low");
    a_addr_setup: assert property (s_open |-> $past(EB_ADDR_OE) && $stable(EB_ADDR))
        else $error("address not set up");
    a_rnw_setup: assert property (s_open |-> $stable(EB_RNW))
        else $error("direction moved at select");
    a_rnw_hold: assert property ($fell(cs_on) |-> $stable(EB_RNW))
        else $error("direction moved at release");
    a_wdata_setup: assert property ($rose(cs_on) && !EB_RNW |-> $past(EB_DATA_OE))
        else $error("write data not set up");
    a_wdata_hold: assert property ($fell(cs_on) && !EB_RNW
        |-> EB_DATA_OE && $stable(EB_DATA_O))
        else $error("write data not held");
    a_oe_track: assert property (!EB_OE_N == (cs_on && EB_RNW))
        else $error("strobe apart from select");
    a_read_quiet: assert property ((cs_on || $fell(cs_on)) && EB_RNW |-> !EB_DATA_OE)
        else $error("data driven on read");
    a_start_pulse: assert property ($fell(EB_START_N) |-> s_open ##1 EB_START_N)
        else $error("start pulse wrong");
    a_size_setup: assert property ($rose(cs_on) && EB_SIZE_OE
        |-> $past(EB_SIZE_OE) && $stable(EB_SIZE))
        else $error("size not set up");
    // ack is registered, so the close may lag it by one edge
    a_ack_ends: assert property (cs_on && !EB_ACK_N |-> ##[1:2] !cs_on)
        else $error("ack did not close window");
endmodule
bind lbn_access lbn_access_sva u_sva (.*);
`default_nettype wire

/* sim/lbn_target_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lbn_target_model (
    input  wire logic        clk,       // bus clock
    input  wire logic        rst,       // async reset
    input  wire logic [7:0]  cs_n,      // selects
    input  wire logic        rnw,       // direction
    input  wire logic [25:0] addr,      // address
    input  wire logic [31:0] wdata,     // write data
    input  wire logic [7:0]  ack_after, // 0 never acks
    output logic      [31:0] rdata,     // read data
    output logic             ack_n      // acknowledge
);
    logic [31:0] mem [16];
    int          cnt;
    // ----
    // sixteen word store
    // ----
    initial for (int i = 0; i < 16; i++) mem[i] = 32'hc3a5_0000 + i;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            ack_n <= 1'b1;
            rdata <= 32'h0000_0000;
        end else if (~&cs_n) begin
            cnt <= cnt + 1;
            ack_n <= !(ack_after != 0 && cnt + 1 >= ack_after);
            if (rnw) rdata <= mem[addr[3:0]];
            else begin
                mem[addr[3:0]] <= wdata;
                rdata <= ~rdata;
            end
        end else begin
            cnt <= 0;
            ack_n <= 1'b1;
            // released bus toggles so a stale word is never mistaken for data
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire

/* sim/lbn_access_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module lbn_access_bench;
    logic        CORE_CLK, RST, EB_CLK, CFG_WE, CFG_ENABLE, REQ_VALID, REQ_RNW;
    logic        BUSY, DONE, REFUSED, ACKED, STAT_ENABLE, EB_OE_N, EB_RNW, EB_ADDR_OE;
    logic        EB_DATA_OE, EB_ACK_N, EB_START_N, EB_SIZE_OE;
    logic [2:0]  CFG_SEL, REQ_CS;
    logic [7:0]  CFG_WAIT_PRIMARY, CFG_WAIT_EXTRA, EB_CS_N, ack_after, seen_sel;
    logic [1:0]  CFG_TURNAROUND, CFG_MODE, REQ_SIZE, STAT_TURN, STAT_MODE, EB_SIZE, got_size;
    logic [25:0] REQ_ADDR, EB_ADDR, got_addr;
    logic [31:0] REQ_WDATA, RDATA, EB_DATA_O, EB_DATA_I;
    logic [15:0] STAT_WAIT;
    logic [31:0] shadow [16];
    logic [15:0] wait_tbl [8];
    logic [1:0]  mode_tbl [8];
    logic        seen_start, seen_size;
    int          fail_count, n_compared, run, last_len, cycles;

    lbn_access DUT (.*);
    lbn_target_model u_target (.clk(EB_CLK), .rst(RST), .cs_n(EB_CS_N), .rnw(EB_RNW),
        .addr(EB_ADDR), .wdata(EB_DATA_O), .ack_after(ack_after), .rdata(EB_DATA_I),
        .ack_n(EB_ACK_N));

    initial begin
        CORE_CLK = 1'b0;
        forever #2 CORE_CLK = ~CORE_CLK;
    end
    // bus edges alternate odd and even times, so every other one shares a time step with a core edge
    initial begin
        EB_CLK = 1'b0;
        #3;
        forever begin
            EB_CLK = ~EB_CLK;
            #15;
        end
    end
    // ----
    // bus monitor
    // ----
    always @(posedge EB_CLK) begin
        seen_sel |= ~EB_CS_N;
        seen_start |= !EB_START_N;
        seen_size |= EB_SIZE_OE;
        if (~&EB_CS_N && run == 0) {got_size, got_addr} = {EB_SIZE, EB_ADDR};
        if (~&EB_CS_N) run++;
        else if (run != 0) begin
            last_len = run;
            run = 0;
        end
    end
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("BAD %0t run hung", $time);
            stop_test;
        end
    end

    task automatic stop_test;
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_len(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("BAD %0t window %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic cfg(input int s, input logic en, input logic [15:0] w, input logic [1:0] m);
        CFG_WE = 1'b1;
        CFG_SEL = s[2:0];
        CFG_ENABLE = en;
        {CFG_WAIT_EXTRA, CFG_WAIT_PRIMARY} = w;
        CFG_TURNAROUND = 2'($urandom);
        CFG_MODE = m;
        @(negedge CORE_CLK);
        CFG_WE = 1'b0;
        @(negedge CORE_CLK);
        chk_val({STAT_ENABLE, STAT_MODE, STAT_TURN, STAT_WAIT}, {en, m, CFG_TURNAROUND, w});
        wait_tbl[s] = w;
        mode_tbl[s] = m;
    endtask
    task automatic access(input int s, input logic rnw, input int idx, input logic [7:0] ack);
        int n;
        ack_after = ack;
        seen_sel = 8'h00;
        seen_start = 1'b0;
        seen_size = 1'b0;
        REQ_VALID = 1'b1;
        REQ_CS = s[2:0];
        REQ_RNW = rnw;
        REQ_ADDR = {22'($urandom), idx[3:0]};
        REQ_WDATA = $urandom;
        REQ_SIZE = 2'($urandom);
        @(negedge CORE_CLK);
        REQ_VALID = 1'b0;
        n = 0;
        while (DONE !== 1'b1 && n < 4000) begin
            @(negedge CORE_CLK);
            n++;
        end
        chk_val(DONE, 1);
        if (rnw) chk_val(RDATA, shadow[idx]);
        else shadow[idx] = REQ_WDATA;
        chk_val(seen_sel, 8'h01 << s);
        chk_val(got_addr, REQ_ADDR);
        if (mode_tbl[s] == 2) chk_val(got_size, REQ_SIZE);
        if (ack == 0) chk_len(last_len, 2 + wait_tbl[s], 2 + wait_tbl[s]);
        else chk_len(last_len, 2 + ack, 2 + ack);
        chk_val(ACKED, ack != 0);
        chk_val({seen_start, seen_size}, {mode_tbl[s] != 0, mode_tbl[s] == 2});
    endtask

    initial begin
        void'($urandom(32'h21e4ee64));
        for (int i = 0; i < 16; i++) shadow[i] = 32'hc3a5_0000 + i;
        {CFG_WE, CFG_SEL, CFG_ENABLE, CFG_WAIT_PRIMARY, CFG_WAIT_EXTRA} = '0;
        {CFG_TURNAROUND, CFG_MODE, REQ_VALID, REQ_CS, REQ_ADDR} = '0;
        {REQ_WDATA, REQ_RNW, REQ_SIZE, ack_after} = '0;
        {fail_count, n_compared, run, last_len, cycles} = '0;
        RST = 1'b1;
        repeat (16) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RST = 1'b0;
        repeat (30) @(negedge CORE_CLK);
        for (int s = 0; s < 8; s++) cfg(s, 1'b1, 16'($urandom_range(0, 6)), 2'(s % 3));
        for (int s = 0; s < 8; s++) begin
            automatic int idx = $urandom_range(0, 15);
            access(s, 1'b0, idx, 8'h00);
            access(s, 1'b1, idx, 8'h00);
        end
        cfg(0, 1'b1, 16'h0028, 2'h0);
        for (int a = 1; a < 4; a++) access(0, 1'b1, $urandom_range(0, 15), 8'(a));
        // both wait bytes in use: window of 260 periods
        cfg(1, 1'b1, 16'h0102, 2'h1);
        access(1, 1'b0, 5, 8'h00);
        access(1, 1'b1, 5, 8'h00);
        cfg(7, 1'b0, 16'h0000, 2'h0);
        REQ_VALID = 1'b1;
        REQ_CS = 3'h7;
        @(negedge CORE_CLK);
        REQ_VALID = 1'b0;
        chk_val({REFUSED, BUSY}, 2'b10);
        repeat (40) @(negedge CORE_CLK);
        chk_val(EB_CS_N, 8'hff);
        stop_test;
    end
endmodule
`default_nettype wire
